// *** cbi_pkg.sv ***
/*
  Shared constants and types for the processor bus interface and
  interrupt entry block: bus widths, vector addresses, synchroniser
  lane map and the interrupt entry sequencer states.
  Assumes a single sys_clk domain; control pin inputs are synchronised, address, data and read/write pin inputs are not.
*/
`default_nettype none

package cbi_pkg;

  ////////////////////////////////////////////////////////////////////
  localparam int unsigned ADDR_W     = 20;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned PC_W       = 16;
  localparam int unsigned UPPER_W    = 4;
  localparam int unsigned REG_IDX_W  = 6;

  // Address lines that take part in internal register selection
  localparam int unsigned REG_LO_MSB = 3;
  localparam int unsigned REG_HI_LSB = 8;
  localparam int unsigned REG_HI_MSB = 9;

  localparam logic [UPPER_W-1:0] UPPER_ZERO  = 4'h0;
  localparam logic [PC_W-1:0]    VEC_NMI_LO  = 16'hFFFA;
  localparam logic [PC_W-1:0]    VEC_NMI_HI  = 16'hFFFB;
  localparam logic [PC_W-1:0]    VEC_IRQ_LO  = 16'hFFFE;
  localparam logic [PC_W-1:0]    VEC_IRQ_HI  = 16'hFFFF;
  localparam logic [PC_W-1:0]    STACK_OFF_0 = 16'h0000;
  localparam logic [PC_W-1:0]    STACK_OFF_1 = 16'h0001;
  localparam logic [PC_W-1:0]    STACK_OFF_2 = 16'h0002;

  ////////////////////////////////////////////////////////////////////
  // Synchroniser lanes
  localparam int unsigned SI_PH0  = 0;
  localparam int unsigned SI_AEC  = 1;
  localparam int unsigned SI_REL  = 2;
  localparam int unsigned SI_RSEL = 3;
  localparam int unsigned SI_MAP  = 4;
  localparam int unsigned SI_NMI  = 5;
  localparam int unsigned SI_IRQ  = 6;
  localparam int unsigned SI_FLA  = 7;
  localparam int unsigned SI_FLB  = 8;
  localparam int unsigned SYNC_W  = 9;
  // Every lane idles high (pull-ups, clock high after reset)
  localparam logic [SYNC_W-1:0] SYNC_RST = 9'h1FF;

  typedef enum logic [2:0]
  {
    SEQ_IDLE,
    SEQ_PUSH_PCH,
    SEQ_PUSH_PCL,
    SEQ_PUSH_P,
    SEQ_VEC_LO,
    SEQ_VEC_HI
  } cbi_seq_t;

endpackage

`default_nettype wire

// *** cbi_sync.sv ***
/*
  Multi-lane input synchroniser with edge detection.
  Each lane passes three flip-flops; a new level is accepted only
  when the second and third stages agree. Assumes synchronous reset.
*/
`default_nettype none

module cbi_sync #(
  parameter int unsigned        W       = 1,
  parameter logic [W-1:0]       RST_VAL = '1
) (
  input  wire logic         sys_clk,  // System clock
  input  wire logic         srst,     // Synchronous reset, high
  input  wire logic [W-1:0] async_in, // Raw pin levels
  output logic      [W-1:0] level,    // Filtered level
  output logic      [W-1:0] fell      // One-cycle falling pulse
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end
    else
    begin
      stage1 <= async_in;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      level <= RST_VAL;
      fell  <= '0;
    end
    else
    begin
      level <= (level & ~agree) | (stage3 & agree);
      fell  <= level & ~stage3 & agree;
    end
  end

endmodule

`default_nettype wire

// *** cbi_bus_irq.sv ***
/*
  Processor system bus interface with interrupt entry sequencing.
  Drives the address, data, read/write and mapped-access pins for the
  core, yields them to external bus masters, decodes internal register
  selection and runs the stack push / vector fetch on interrupts.
  Assumes the core presents its next bus request before each falling
  edge of the phase-zero clock, and that the phase-zero clock is much
  slower than sys_clk (it is sampled as a pin).
*/
// Summary of operation
// - 20-bit address bus floats when bus release or address enable is low.
// - Internal register select decodes address lines 0-3, 8 and 9 only.
// - Fetch marker is high for whole opcode fetch cycles, low otherwise.
// - Address enable high drives address, map and read/write; low floats them.
// - Bus release low floats address, map and read/write for other masters.
// - Either enable low at phase-zero fall halts the cycle, outputs held.
// - Mapped access drives map low and blocks internal register selection.
// - Unmapped access keeps map high and upper four address lines low.
// - Map and register select both low externally: test mode, data stays driven.
// - Data moves over an 8-bit two-way data bus.
// - Read/write high except on writes; floats when either enable is low.
// - Flag inputs synchronised; a falling edge with its mask bit set pulls interrupt line low.
// - NMI falling edge starts NMI entry at the next opcode fetch.
// - NMI is taken regardless of the interrupt mask flag.
// - NMI entry pushes PC high, PC low, status; vector from FFFA/FFFB.
// - No interrupt is recognised unless both enables are high.
// - Map opcode inhibits all interrupts until a no-operation opcode runs.
// - Interrupt line sampled in phase two; edge counts only with mask clear.
// - IRQ entry stacks PC and status, sets mask, vector from FFFE/FFFF.
`default_nettype none

module cbi_bus_irq (
  input  wire logic        sys_clk,             // System clock, 100 MHz
  input  wire logic        srst,                // Synchronous reset, high
  input  wire logic        phase_zero_clock,    // Bus cycle clock pin
  input  wire logic        address_enable_in,   // Address enable pin
  input  wire logic        bus_release_n,       // Bus release request, low
  input  wire logic        reg_select_n,        // Register select pin, low
  input  wire logic [19:0] address_lines_i,     // Address pins, in
  output logic      [19:0] address_lines_o,     // Address pins, out
  output logic             address_lines_oe,    // Address pins, enable
  input  wire logic [7:0]  data_lines_i,        // Data pins, in
  output logic      [7:0]  data_lines_o,        // Data pins, out
  output logic             data_lines_oe,       // Data pins, enable
  input  wire logic        rw_i,                // Read/write pin, in
  output logic             rw_o,                // Read/write pin, out
  output logic             rw_oe,               // Read/write pin, enable
  input  wire logic        map_n_i,             // Mapped indicator pin, in
  output logic             map_n_o,             // Mapped indicator, out
  output logic             map_n_oe,            // Mapped indicator, enable
  output logic             opcode_fetch_marker, // Opcode fetch cycle
  input  wire logic        nmi_n,               // Non-maskable request pin
  input  wire logic        edge_irq_input_a_n,  // Edge flag input A
  input  wire logic        edge_irq_input_b_n,  // Edge flag input B
  input  wire logic        flag_mask_a,         // Mask bit for flag A
  input  wire logic        flag_mask_b,         // Mask bit for flag B
  input  wire logic        flag_clear,          // Flag request cleared
  input  wire logic        irq_n_i,             // Interrupt line, in
  output logic             irq_n_o,             // Interrupt line, out
  output logic             irq_n_oe,            // Interrupt line, enable
  input  wire logic [19:0] core_addr,           // Next cycle address
  input  wire logic        core_mapped,         // Next cycle is mapped
  input  wire logic        core_write,          // Next cycle writes
  input  wire logic [7:0]  core_wdata,          // Next cycle write data
  input  wire logic        core_fetch,          // Next cycle is a fetch
  input  wire logic [15:0] core_pc,             // PC of the pending fetch
  input  wire logic [15:0] core_sp,             // Stack pointer
  input  wire logic [7:0]  core_status,         // Status register
  input  wire logic        core_i_flag,         // Interrupt mask flag
  input  wire logic        core_map_op,         // Map opcode executed
  input  wire logic        core_nop_op,         // No-op opcode executed
  output logic      [7:0]  core_rdata,          // Read data of the cycle
  output logic             cycle_done,          // Core cycle completed
  output logic             pc_load,             // Load vector into PC
  output logic      [15:0] pc_value,            // Vector address
  output logic             set_i_flag,          // Set the mask flag
  output logic             reg_sel,             // Internal register hit
  output logic      [5:0]  reg_index,           // Register index
  output logic             reg_write,           // Register access writes
  output logic             test_mode            // Data bus test mode
);

  ////////////////////////////////////////////////////////////////////
  // Pin synchronisation

  logic [cbi_pkg::SYNC_W-1:0] pin_raw;
  logic [cbi_pkg::SYNC_W-1:0] pin_lvl;
  logic [cbi_pkg::SYNC_W-1:0] pin_fell;

  always_comb
  begin
    pin_raw                    = '1;
    pin_raw[cbi_pkg::SI_PH0]   = phase_zero_clock;
    pin_raw[cbi_pkg::SI_AEC]   = address_enable_in;
    pin_raw[cbi_pkg::SI_REL]   = bus_release_n;
    pin_raw[cbi_pkg::SI_RSEL]  = reg_select_n;
    pin_raw[cbi_pkg::SI_MAP]   = map_n_i;
    pin_raw[cbi_pkg::SI_NMI]   = nmi_n;
    pin_raw[cbi_pkg::SI_IRQ]   = irq_n_i;
    pin_raw[cbi_pkg::SI_FLA]   = edge_irq_input_a_n;
    pin_raw[cbi_pkg::SI_FLB]   = edge_irq_input_b_n;
  end

  cbi_sync #(
    .W       (cbi_pkg::SYNC_W),
    .RST_VAL (cbi_pkg::SYNC_RST)
  ) u_sync (
    .sys_clk  (sys_clk),
    .srst     (srst),
    .async_in (pin_raw),
    .level    (pin_lvl),
    .fell     (pin_fell)
  );

  ////////////////////////////////////////////////////////////////////
  // Address helpers

  function automatic logic [19:0] unmapped_addr(input logic [15:0] a);
    unmapped_addr = {cbi_pkg::UPPER_ZERO, a};
  endfunction

  function automatic logic [19:0] stack_addr(input logic [15:0] sp,
                                             input logic [15:0] off);
    stack_addr = unmapped_addr(sp - off);
  endfunction

  function automatic logic [5:0] reg_decode(input logic [19:0] a);
    reg_decode = {a[cbi_pkg::REG_HI_MSB:cbi_pkg::REG_HI_LSB],
                  a[cbi_pkg::REG_LO_MSB:0]};
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Cycle timing

  logic             phase_two;
  logic             cycle_end;
  logic             bus_en;
  logic             advance;
  logic             halt;

  assign phase_two = pin_lvl[cbi_pkg::SI_PH0];
  assign cycle_end = pin_fell[cbi_pkg::SI_PH0];
  assign bus_en    = pin_lvl[cbi_pkg::SI_AEC] & pin_lvl[cbi_pkg::SI_REL];
  assign halt      = cycle_end & ~bus_en;
  assign advance   = cycle_end & bus_en;

  ////////////////////////////////////////////////////////////////////
  // Interrupt requests

  cbi_pkg::cbi_seq_t seq_state;
  cbi_pkg::cbi_seq_t next_seq_state;
  logic              seq_nmi;
  logic              nmi_pend;
  logic              irq_pend;
  logic              flag_pend;
  logic              int_inhibit;
  logic              bus_write;
  logic              bus_mapped;
  logic              bus_fetch;
  logic [19:0]       bus_addr;
  logic [7:0]        bus_wdata;
  logic [7:0]        vec_lo;
  logic              take_nmi;
  logic              take_irq;
  logic              take;
  logic              flag_edge;
  logic              irq_edge;

  assign take_nmi  = nmi_pend;
  assign take_irq  = irq_pend & ~core_i_flag;
  // Entry only on a completed fetch cycle with both enables high
  assign take      = advance && seq_state == cbi_pkg::SEQ_IDLE && bus_fetch
                     && !int_inhibit && (take_nmi || take_irq);
  assign flag_edge = (pin_fell[cbi_pkg::SI_FLA] & flag_mask_a)
                   | (pin_fell[cbi_pkg::SI_FLB] & flag_mask_b);
  assign irq_edge  = pin_fell[cbi_pkg::SI_IRQ] & phase_two & ~core_i_flag;

  // Set beats clear on every request flag
  always_ff @(posedge sys_clk)
  begin
    if (srst)
      nmi_pend <= 1'b0;
    else if (pin_fell[cbi_pkg::SI_NMI])
      nmi_pend <= 1'b1;
    else if (take && take_nmi)
      nmi_pend <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      irq_pend <= 1'b0;
    else if (irq_edge)
      irq_pend <= 1'b1;
    else if (take && !take_nmi)
      irq_pend <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      flag_pend <= 1'b0;
    else if (flag_edge)
      flag_pend <= 1'b1;
    else if (flag_clear)
      flag_pend <= 1'b0;
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
      int_inhibit <= 1'b0;
    else if (core_map_op)
      int_inhibit <= 1'b1;
    else if (core_nop_op)
      int_inhibit <= 1'b0;
  end

  // Open-drain: only ever pulls low
  assign irq_n_o  = 1'b0;
  assign irq_n_oe = flag_pend;

  ////////////////////////////////////////////////////////////////////
  // Entry sequencer

  always_comb
  begin
    next_seq_state = seq_state;
    if (advance)
    begin
      case (seq_state)
        cbi_pkg::SEQ_IDLE:     next_seq_state = take ? cbi_pkg::SEQ_PUSH_PCH
                                                     : cbi_pkg::SEQ_IDLE;
        cbi_pkg::SEQ_PUSH_PCH: next_seq_state = cbi_pkg::SEQ_PUSH_PCL;
        cbi_pkg::SEQ_PUSH_PCL: next_seq_state = cbi_pkg::SEQ_PUSH_P;
        cbi_pkg::SEQ_PUSH_P:   next_seq_state = cbi_pkg::SEQ_VEC_LO;
        cbi_pkg::SEQ_VEC_LO:   next_seq_state = cbi_pkg::SEQ_VEC_HI;
        default:               next_seq_state = cbi_pkg::SEQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      seq_state <= cbi_pkg::SEQ_IDLE;
      seq_nmi   <= 1'b0;
    end
    else
    begin
      seq_state <= next_seq_state;
      if (take)
        seq_nmi <= take_nmi;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus cycle registers: loaded only on a non-halted cycle end

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      bus_addr   <= '0;
      bus_write  <= 1'b0;
      bus_mapped <= 1'b0;
      bus_wdata  <= '0;
      bus_fetch  <= 1'b0;
    end
    else if (advance)
    begin
      bus_mapped <= 1'b0;
      bus_fetch  <= 1'b0;
      bus_write  <= 1'b1;
      case (next_seq_state)
        cbi_pkg::SEQ_PUSH_PCH:
        begin
          bus_addr  <= stack_addr(core_sp, cbi_pkg::STACK_OFF_0);
          bus_wdata <= core_pc[15:8];
        end
        cbi_pkg::SEQ_PUSH_PCL:
        begin
          bus_addr  <= stack_addr(core_sp, cbi_pkg::STACK_OFF_1);
          bus_wdata <= core_pc[7:0];
        end
        cbi_pkg::SEQ_PUSH_P:
        begin
          bus_addr  <= stack_addr(core_sp, cbi_pkg::STACK_OFF_2);
          bus_wdata <= core_status;
        end
        cbi_pkg::SEQ_VEC_LO:
        begin
          bus_write <= 1'b0;
          bus_addr  <= unmapped_addr(seq_nmi ? cbi_pkg::VEC_NMI_LO
                                             : cbi_pkg::VEC_IRQ_LO);
        end
        cbi_pkg::SEQ_VEC_HI:
        begin
          bus_write <= 1'b0;
          bus_addr  <= unmapped_addr(seq_nmi ? cbi_pkg::VEC_NMI_HI
                                             : cbi_pkg::VEC_IRQ_HI);
        end
        default:
        begin
          if (seq_state == cbi_pkg::SEQ_VEC_HI)
          begin
            // First fetch of the handler, core has not seen the vector yet
            bus_write <= 1'b0;
            bus_fetch <= 1'b1;
            bus_addr  <= unmapped_addr({data_lines_i, vec_lo});
          end
          else
          begin
            bus_write  <= core_write;
            bus_mapped <= core_mapped;
            bus_fetch  <= core_fetch;
            bus_wdata  <= core_wdata;
            bus_addr   <= core_mapped ? core_addr
                                      : unmapped_addr(core_addr[15:0]);
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Core side results

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      core_rdata <= '0;
      vec_lo     <= '0;
      cycle_done <= 1'b0;
      pc_load    <= 1'b0;
      pc_value   <= '0;
      set_i_flag <= 1'b0;
    end
    else
    begin
      cycle_done <= advance && seq_state == cbi_pkg::SEQ_IDLE && !take;
      pc_load    <= advance && seq_state == cbi_pkg::SEQ_VEC_HI;
      set_i_flag <= advance && seq_state == cbi_pkg::SEQ_VEC_HI && !seq_nmi;
      if (advance)
        core_rdata <= data_lines_i;
      if (advance && seq_state == cbi_pkg::SEQ_VEC_LO)
        vec_lo <= data_lines_i;
      if (advance && seq_state == cbi_pkg::SEQ_VEC_HI)
        pc_value <= {data_lines_i, vec_lo};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Pin drive

  assign address_lines_o     = bus_addr;
  assign address_lines_oe    = bus_en;
  assign map_n_o             = ~bus_mapped;
  assign map_n_oe            = bus_en;
  assign rw_o                = ~bus_write;
  assign rw_oe               = bus_en;
  assign data_lines_o        = bus_wdata;
  assign data_lines_oe       = bus_write & (bus_en | test_mode);
  assign opcode_fetch_marker = bus_fetch;

  ////////////////////////////////////////////////////////////////////
  // Register selection and test mode

  logic map_high;
  logic map_ext_low;

  // Own drive wins while enabled for map_high; map_ext_low reads the pin unless own drive is low
  assign map_high    = map_n_oe ? map_n_o : pin_lvl[cbi_pkg::SI_MAP];
  assign map_ext_low = ~pin_lvl[cbi_pkg::SI_MAP] & ~(map_n_oe & ~map_n_o);

  always_ff @(posedge sys_clk)
  begin
    if (srst)
    begin
      reg_sel   <= 1'b0;
      reg_index <= '0;
      reg_write <= 1'b0;
      test_mode <= 1'b0;
    end
    else
    begin
      reg_sel   <= ~pin_lvl[cbi_pkg::SI_RSEL] & map_high;
      reg_index <= reg_decode(bus_en ? bus_addr : address_lines_i);
      reg_write <= bus_en ? bus_write : ~rw_i;
      test_mode <= ~pin_lvl[cbi_pkg::SI_RSEL] & map_ext_low;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_halt_edge;
    cycle_end && !bus_en;
  endsequence

  sequence s_held_bus;
    $stable(address_lines_o) && $stable(rw_o) && $stable(map_n_o)
      && $stable(data_lines_o);
  endsequence

  sequence s_vec_hi_done;
    advance && seq_state == cbi_pkg::SEQ_VEC_HI;
  endsequence

  addr_float_a: assert property (!bus_en |-> !address_lines_oe)
    else $error("address bus driven while disabled");

  ctrl_float_a: assert property (!bus_en |-> !map_n_oe && !rw_oe)
    else $error("map or read/write driven while disabled");

  halt_hold_a: assert property (s_halt_edge |=> s_held_bus)
    else $error("bus outputs changed on a halted cycle");

  unmapped_upper_a: assert property (map_n_o |-> address_lines_o[19:16] == 4'h0)
    else $error("upper address lines high on unmapped access");

  mapped_block_a: assert property (map_n_oe && !map_n_o |=> !reg_sel)
    else $error("register selected during mapped access");

  test_drive_a: assert property (test_mode && bus_write |-> data_lines_oe)
    else $error("data bus floated in test mode");

  data_float_a: assert property (!test_mode && !bus_en |-> !data_lines_oe)
    else $error("data bus driven while disabled");

  flag_pull_a: assert property (flag_edge |=> irq_n_oe)
    else $error("flag edge did not pull the interrupt line");

  take_gate_a: assert property (take |-> bus_en && !int_inhibit)
    else $error("interrupt taken while disabled or inhibited");

  nmi_vector_a: assert property ((s_vec_hi_done and seq_nmi)
                                 |-> address_lines_o[15:0] == cbi_pkg::VEC_NMI_HI)
    else $error("non-maskable vector high byte fetched from wrong address");

  irq_vector_a: assert property ((s_vec_hi_done and !seq_nmi)
                                 |=> set_i_flag && pc_load)
    else $error("maskable entry did not set the mask flag");

  push_order_a: assert property (advance && seq_state == cbi_pkg::SEQ_PUSH_PCH
                                 |=> seq_state == cbi_pkg::SEQ_PUSH_PCL
                                     && !rw_o && data_lines_o == core_pc[7:0])
    else $error("stack push order broken");

  fetch_marker_a: assert property ($rose(opcode_fetch_marker) |-> $past(advance))
    else $error("fetch marker rose outside a cycle boundary");

endmodule

`default_nettype wire

// *** cbi_mem_model.sv ***
/*
  Memory model on the far side of the data bus.
  Assumes the bench resolves the other shared pins itself.
*/
`default_nettype none
module cbi_mem_model (
  input  wire logic        sys_clk,  // System clock
  input  wire logic [19:0] addr,     // Address pins
  input  wire logic        rw,       // High reads
  input  wire logic        rw_oe,    // Read/write driven
  input  wire logic [7:0]  wdata,    // Device data
  input  wire logic        wdata_oe, // Device drives data
  output logic      [7:0]  data      // Resolved data wire
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] churn = 8'h5a;
  // Released wire churns so a stale byte never passes
  always @(posedge sys_clk) churn <= ~churn + 8'h01;
  always_comb
    if (wdata_oe) data = wdata;
    else if (rw_oe && rw) data = ~addr[7:0];
    else data = churn;
endmodule
`default_nettype wire

// *** testbench.sv ***
/*
  Self-checking bench for the bus interface and interrupt entry.
  Assumes the designer's latencies: cycle end four edges after fall.
*/
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin fail_count++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 0, srst = 1, phase_zero_clock = 1, address_enable_in = 1, bus_release_n = 1;
  logic reg_select_n = 1, nmi_n = 1, edge_irq_input_a_n = 1, flag_mask_a = 0, flag_clear = 0;
  logic core_mapped = 0, core_write = 0, core_fetch = 0, map_ext = 1, quiet = 0, i_flag = 1;
  logic map_op = 0, nop_op = 0, set_i_flag, reg_write;
  logic [4:0]  oes;
  logic [40:0] exp_bus, got_bus;
  logic [19:0] core_addr = 0, address_lines_i, address_lines_o;
  logic [15:0] core_pc = 0, core_sp = 0, pc_value;
  logic [7:0]  core_wdata = 0, core_status = 0, data_lines_i, data_lines_o, core_rdata;
  logic [7:0]  prev_rd = 8'hff;
  logic [5:0]  reg_index;
  logic [31:0] rnd = 32'h0001_2817;
  logic [40:0] exq[$];
  logic address_lines_oe, data_lines_oe, rw_i, rw_o, rw_oe, map_n_i, map_n_o, map_n_oe;
  logic opcode_fetch_marker, irq_n_i, irq_n_o, irq_n_oe, cycle_done, pc_load, reg_sel, test_mode;
  int fail_count = 0, comparisons = 0, loads = 0;
  always #5 sys_clk = ~sys_clk;
  assign irq_n_i = irq_n_oe ? irq_n_o : 1'b1;
  assign map_n_i = map_n_oe ? map_n_o : map_ext;
  assign rw_i = rw_oe ? rw_o : 1'b1;
  assign oes = {address_lines_oe, rw_oe, map_n_oe, data_lines_oe, test_mode};
  assign address_lines_i = address_lines_oe ? address_lines_o : ~address_lines_o;
  cbi_mem_model i_mem (.sys_clk, .addr(address_lines_o), .rw(rw_o), .rw_oe,
    .wdata(data_lines_o), .wdata_oe(data_lines_oe), .data(data_lines_i));
  // Mask flag set for the NMI scenario, cleared from the maskable entry scenario to the end of the run
  cbi_bus_irq i_dut (.sys_clk, .srst, .phase_zero_clock, .address_enable_in, .bus_release_n,
    .reg_select_n, .address_lines_i, .address_lines_o, .address_lines_oe, .data_lines_i,
    .data_lines_o, .data_lines_oe, .rw_i, .rw_o, .rw_oe, .map_n_i, .map_n_o, .map_n_oe,
    .opcode_fetch_marker, .nmi_n, .edge_irq_input_a_n, .edge_irq_input_b_n(1'b1),
    .flag_mask_a, .flag_mask_b(1'b0), .flag_clear, .irq_n_i, .irq_n_o, .irq_n_oe, .core_addr,
    .core_mapped, .core_write, .core_wdata, .core_fetch, .core_pc, .core_sp, .core_status,
    .core_i_flag(i_flag), .core_map_op(map_op), .core_nop_op(nop_op), .core_rdata, .cycle_done,
    .pc_load, .pc_value, .set_i_flag, .reg_sel, .reg_index, .reg_write, .test_mode);
  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic ph();
    repeat (8) @(negedge sys_clk);
    phase_zero_clock = 0;
    repeat (8) @(negedge sys_clk);
    phase_zero_clock = 1;
  endtask
  task automatic cyc(input logic w, input logic m, input logic f);
    rnd = step(rnd);
    {core_addr, core_write, core_mapped, core_fetch} = {rnd[19:0], w, m, f};
    {core_wdata, core_sp, core_pc, core_status} = {rnd[27:20], rnd[31:16], rnd[15:0], rnd[7:0]};
    if (address_enable_in && bus_release_n && !quiet)
    begin
      exq.push_back({m ? rnd[19:0] : {4'h0, rnd[15:0]}, !w, !m, f, 1'b1, w,
        w ? rnd[27:20] : 8'h00, prev_rd});
      prev_rd = w ? rnd[27:20] : ~rnd[7:0];
    end
    ph();
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////
  // Outputs read at the falling edge, settled since the launching edge
  always @(negedge sys_clk)
  begin
    if (cycle_done === 1'b1 && exq.size() > 0)
    begin
      exp_bus = exq.pop_front();
      got_bus = {address_lines_o, rw_o, map_n_o, opcode_fetch_marker, address_lines_oe,
        data_lines_oe, rw_o ? 8'h00 : data_lines_o, core_rdata};
      `CHK("bus", exp_bus, got_bus)
    end
    if (pc_load === 1'b1)
    begin
      loads++;
      `CHK("vector", {i_flag ? 16'h0405 : 16'h0001, !i_flag}, {pc_value, set_i_flag})
    end
  end
  initial
  begin
    #50000;
    fail_count++;
    close_out();
  end
  initial
  begin
    repeat (2) @(negedge sys_clk);
    srst = 0;
    repeat (14) cyc(rnd[0], rnd[1], rnd[2]);
    cyc(0, 0, 0);
    reg_select_n = 0;
    repeat (6) @(negedge sys_clk);
    `CHK("regsel", {1'b1, core_addr[9:8], core_addr[3:0]}, {reg_sel, reg_index})
    `CHK("regwr", 1'b0, reg_write)
    cyc(0, 1, 0);
    `CHK("mapblock", 1'b0, reg_sel)
    reg_select_n = 1;
    cyc(1, 0, 0);
    for (int k = 0; k < 2; k++)
    begin
      {address_enable_in, bus_release_n, map_ext, reg_select_n} = {k[0], !k[0], !k[0], !k[0]};
      cyc(1, 1, 1);
      `CHK("halt", {3'b000, k[0], k[0]}, oes)
    end
    {address_enable_in, bus_release_n, map_ext, reg_select_n} = 4'hf;
    repeat (2) cyc(0, 0, 1);
    quiet = 1;
    nmi_n = 0;
    repeat (8) cyc(0, 0, 1);
    `CHK("nmi", 1, loads)
    {flag_mask_a, i_flag, map_op} = 3'b101;
    @(negedge sys_clk);
    {map_op, edge_irq_input_a_n} = 2'b00;
    repeat (10) @(negedge sys_clk);
    `CHK("flag", 1'b1, irq_n_oe)
    repeat (8) cyc(0, 0, 1);
    `CHK("inhibit", 1, loads)
    nop_op = 1;
    @(negedge sys_clk);
    nop_op = 0;
    repeat (8) cyc(0, 0, 1);
    `CHK("irq", 2, loads)
    flag_clear = 1;
    @(negedge sys_clk);
    {flag_clear, flag_mask_a, edge_irq_input_a_n} = 3'b001;
    repeat (4) @(negedge sys_clk);
    edge_irq_input_a_n = 0;
    repeat (10) @(negedge sys_clk);
    `CHK("masked", 1'b0, irq_n_oe)
    `CHK("drained", 0, exq.size())
    close_out();
  end
endmodule
`default_nettype wire
